// ==== src/wbts_pkg.sv ====
// Constants, timing counts and state encoding for the beacon tone sequencer.
package wbts_pkg;
	localparam int unsigned CLK_HZ     = 200_000_000; // System clock rate.
	localparam int unsigned NSYM       = 162;         // Symbols per message.
	localparam int unsigned MSG_W      = 2 * NSYM;
	localparam logic [7:0]  SYM_LAST   = 8'(NSYM - 1);
	localparam int unsigned TONE_NUM   = 12_000;      // Tone spacing numerator.
	localparam int unsigned TONE_DEN   = 8_192;       // Tone spacing divisor.
	localparam int unsigned FRAC_W     = 13;          // log2 of TONE_DEN.
	localparam int unsigned FREQ_W     = 32 + FRAC_W;
	localparam logic [FREQ_W-1:0] TONE_STEP = FREQ_W'(TONE_NUM);
	// Symbol time is TONE_DEN/TONE_NUM seconds, truncated to whole cycles.
	localparam int unsigned SYM_CYC    =
		32'(longint'(CLK_HZ) * TONE_DEN / TONE_NUM);
	localparam int unsigned POST_MEAS_S = 4;          // Reference window.
	localparam int unsigned POST_MAX_S  = 7;          // Post-message limit.
	localparam int unsigned MEAS_CYC   = 32'(longint'(CLK_HZ) * POST_MEAS_S);
	localparam int unsigned LIMIT_CYC  = 32'(longint'(CLK_HZ) * POST_MAX_S);
	localparam int unsigned MEAS_INT   = 3;           // PPS intervals timed.
	localparam logic [1:0]  PPS_N_MAX  = 2'(MEAS_INT);
	localparam logic [5:0]  START_SEC  = 6'h01;       // Keying second.
	localparam logic [5:0]  SEC_LAST   = 6'h3b;
	localparam logic [5:0]  MIN_LAST   = 6'h3b;
	localparam logic [4:0]  HOUR_LAST  = 5'h17;
	localparam logic [6:0]  MIN_PER_HR = 7'h3c;
	localparam logic [5:0]  FRAME_MIN  = 6'h02;       // Shortest frame.
	localparam int unsigned LON_FIELD  = 20;          // Degrees per field.
	localparam int unsigned LAT_FIELD  = 10;
	localparam int unsigned LON_SQ     = 2;           // Degrees per square.
	localparam logic [7:0]  ASCII_A    = 8'h41;
	localparam logic [7:0]  ASCII_0    = 8'h30;
	localparam logic [31:0] LOC_RST    = 32'h41413030; // Arbitrary start.

	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_WAIT = 2'b01,
		ST_TX   = 2'b10,
		ST_POST = 2'b11
	} wbts_state_e;
endpackage : wbts_pkg

// ==== src/wbts_core.sv ====
// Beacon tone sequencer: slot timing, symbol keying and GPS discipline.
`timescale 1ns/10ps
module wbts_core #(
	parameter int unsigned SYM_CYC   = wbts_pkg::SYM_CYC,
	parameter int unsigned SEC_CYC   = wbts_pkg::CLK_HZ,
	parameter int unsigned MEAS_CYC  = wbts_pkg::MEAS_CYC,
	parameter int unsigned LIMIT_CYC = wbts_pkg::LIMIT_CYC
) (
	// Clock and reset.
	input  wire logic                        i_clk,
	input  wire logic                        i_reset,
	// Operator control and configuration.
	input  wire logic                        i_start,
	input  wire logic                        i_exit,
	input  wire logic [31:0]                 i_base_hz,
	input  wire logic [5:0]                  i_frame_min,
	input  wire logic [5:0]                  i_start_min,
	input  wire logic [wbts_pkg::MSG_W-1:0]  i_msg,
	// GPS receiver, already decoded from the serial stream.
	input  wire logic                        i_pps,
	input  wire logic                        i_gps_valid,
	input  wire logic [4:0]                  i_gps_hour,
	input  wire logic [5:0]                  i_gps_min,
	input  wire logic [5:0]                  i_gps_sec,
	input  wire logic [8:0]                  i_gps_lon,
	input  wire logic [7:0]                  i_gps_lat,
	// Synthesiser and keying.
	output logic                             o_key,
	output logic [wbts_pkg::FREQ_W-1:0]      o_freq,
	output logic [31:0]                      o_ref_corr,
	output logic                             o_corr_valid,
	// Status display.
	output logic [1:0]                       o_state,
	output logic [7:0]                       o_sym_idx,
	output logic [1:0]                       o_tone,
	output logic [4:0]                       o_hour,
	output logic [5:0]                       o_min,
	output logic [5:0]                       o_sec,
	output logic [5:0]                       o_next_min,
	output logic [31:0]                      o_locator
);

	// Refuse counts that the counters and the post window cannot serve.
	if (SYM_CYC < 1 || SEC_CYC < 2 || MEAS_CYC >= LIMIT_CYC) begin : g_bad
		$error("wbts_core: bad timing parameters");
	end

	// True when minute m is a scheduled slot; frames below two act as two.
	function automatic logic slot_ok(input logic [5:0] m,
		input logic [5:0] st, input logic [5:0] fr);
		logic [6:0] d;
		logic [6:0] f;
		f = (fr < wbts_pkg::FRAME_MIN) ? 7'(wbts_pkg::FRAME_MIN) : 7'(fr);
		d = (m >= st) ? 7'(m - st)
			: 7'(7'(m) + wbts_pkg::MIN_PER_HR - 7'(st));
		slot_ok = !m[0] && (d % f == 7'h00);
	endfunction : slot_ok

	// First slot minute strictly after minute m.
	function automatic logic [5:0] next_slot(input logic [5:0] m,
		input logic [5:0] st, input logic [5:0] fr);
		logic [6:0] c;
		logic       found;
		next_slot = m;
		found = 1'b0;
		for (int k = 1; k <= 60; k++) begin
			c = 7'(m) + 7'(k);
			c = (c >= wbts_pkg::MIN_PER_HR) ? c - wbts_pkg::MIN_PER_HR : c;
			if (!found && slot_ok(c[5:0], st, fr)) begin
				next_slot = c[5:0];
				found = 1'b1;
			end
		end
	endfunction : next_slot

	// Synthesiser word in 1/8192 Hz units for a given tone.
	function automatic logic [wbts_pkg::FREQ_W-1:0] freq_of(
		input logic [31:0] base, input logic [1:0] tone);
		freq_of = {base, wbts_pkg::FRAC_W'(0)}
			+ wbts_pkg::FREQ_W'(tone) * wbts_pkg::TONE_STEP;
	endfunction : freq_of

	wbts_pkg::wbts_state_e state_r, state_nxt;
	logic [31:0]                 cnt_r, cnt_nxt;
	logic [31:0]                 tick_r, tick_nxt;
	logic [7:0]                  idx_r, idx_nxt;
	logic [1:0]                  tone_r, tone_nxt;
	logic                        key_r, key_nxt;
	logic [31:0]                 base_r, base_nxt;
	logic [wbts_pkg::FREQ_W-1:0] freq_r, freq_nxt;
	logic [wbts_pkg::MSG_W-1:0]  msg_r, msg_nxt;
	logic [4:0]                  hour_r, hour_nxt;
	logic [5:0]                  min_r, min_nxt, sec_r, sec_nxt;
	logic [5:0]                  next_r, next_nxt;
	logic [31:0]                 loc_r, loc_nxt;
	logic                        pps_d_r, pps_d_nxt;
	logic [1:0]                  pps_n_r, pps_n_nxt;
	logic                        meas_on_r, meas_on_nxt;
	logic [31:0]                 meas_r, meas_nxt;
	logic [31:0]                 corr_r, corr_nxt;
	logic                        cval_r, cval_nxt;
	logic                        gps_done_r, gps_done_nxt;
	logic                        sym_end;

	assign sym_end = (cnt_r == SYM_CYC - 1);

	// Next state for the sequencer, the clock and the GPS discipline.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		tick_nxt = tick_r + 32'h1;
		idx_nxt = idx_r;
		tone_nxt = tone_r;
		key_nxt = key_r;
		base_nxt = base_r;
		freq_nxt = freq_r;
		msg_nxt = msg_r;
		hour_nxt = hour_r;
		min_nxt = min_r;
		sec_nxt = sec_r;
		loc_nxt = loc_r;
		pps_d_nxt = i_pps;
		pps_n_nxt = pps_n_r;
		meas_on_nxt = meas_on_r;
		meas_nxt = meas_r;
		corr_nxt = corr_r;
		cval_nxt = cval_r;
		gps_done_nxt = gps_done_r;
		// The clock keeps running in every state so slots stay aligned.
		if (tick_r == SEC_CYC - 1) begin
			tick_nxt = 32'h0;
			sec_nxt = (sec_r == wbts_pkg::SEC_LAST) ? 6'h00 : sec_r + 6'h01;
			if (sec_r == wbts_pkg::SEC_LAST) begin
				min_nxt = (min_r == wbts_pkg::MIN_LAST) ? 6'h00 : min_r + 6'h01;
				if (min_r == wbts_pkg::MIN_LAST)
					hour_nxt = (hour_r == wbts_pkg::HOUR_LAST) ? 5'h00
						: hour_r + 5'h01;
			end
		end
		case (state_r)
			wbts_pkg::ST_OFF: begin
				if (i_start)
					state_nxt = wbts_pkg::ST_WAIT;
			end
			wbts_pkg::ST_WAIT: begin
				// Key exactly at the start of second START_SEC of a slot minute.
				if (tick_r == 32'h0 && sec_r == wbts_pkg::START_SEC
					&& slot_ok(min_r, i_start_min, i_frame_min)) begin
					state_nxt = wbts_pkg::ST_TX;
					key_nxt = 1'b1;
					cnt_nxt = 32'h0;
					idx_nxt = 8'h00;
					msg_nxt = i_msg;
					base_nxt = i_base_hz;
					tone_nxt = i_msg[1:0];
					freq_nxt = freq_of(i_base_hz, i_msg[1:0]);
				end
			end
			wbts_pkg::ST_TX: begin
				cnt_nxt = cnt_r + 32'h1;
				if (sym_end) begin
					cnt_nxt = 32'h0;
					if (idx_r == wbts_pkg::SYM_LAST) begin
						state_nxt = wbts_pkg::ST_POST;
						key_nxt = 1'b0;
						pps_n_nxt = 2'h0;
						meas_on_nxt = 1'b0;
						gps_done_nxt = 1'b0;
					end else begin
						idx_nxt = idx_r + 8'h01;
						tone_nxt = msg_r[2*(idx_r+8'h01) +: 2];
						freq_nxt = freq_of(base_r,
							msg_r[2*(idx_r+8'h01) +: 2]);
					end
				end
			end
			wbts_pkg::ST_POST: begin
				cnt_nxt = cnt_r + 32'h1;
				// Time the reference against whole GPS seconds.
				if (meas_on_r)
					meas_nxt = meas_r + 32'h1;
				if (i_pps && !pps_d_r) begin
					if (!meas_on_r && pps_n_r == 2'h0) begin
						meas_on_nxt = 1'b1;
						meas_nxt = 32'h0;
					end else if (meas_on_r) begin
						pps_n_nxt = pps_n_r + 2'h1;
						if (pps_n_r + 2'h1 == wbts_pkg::PPS_N_MAX) begin
							meas_on_nxt = 1'b0;
							cval_nxt = 1'b1;
							corr_nxt = 32'(wbts_pkg::MEAS_INT * SEC_CYC)
								- (meas_r + 32'h1);
						end
					end
				end
				// GPS data is parsed once, only here after the message.
				if (i_gps_valid && !gps_done_r) begin
					gps_done_nxt = 1'b1;
					hour_nxt = i_gps_hour;
					min_nxt = i_gps_min;
					sec_nxt = i_gps_sec;
					tick_nxt = 32'h0;
					loc_nxt = {8'(wbts_pkg::ASCII_A + i_gps_lon / wbts_pkg::LON_FIELD),
						8'(wbts_pkg::ASCII_A + i_gps_lat / wbts_pkg::LAT_FIELD),
						8'(wbts_pkg::ASCII_0 + (i_gps_lon % wbts_pkg::LON_FIELD)
							/ wbts_pkg::LON_SQ),
						8'(wbts_pkg::ASCII_0 + i_gps_lat % wbts_pkg::LAT_FIELD)};
				end
				// The window ends well inside the post-message limit.
				if (cnt_r == MEAS_CYC - 1) begin
					state_nxt = wbts_pkg::ST_WAIT;
					meas_on_nxt = 1'b0;
				end
			end
			default: state_nxt = wbts_pkg::ST_OFF;
		endcase
		// Exit wins over the state and the key, even mid-message.
		if (i_exit) begin
			state_nxt = wbts_pkg::ST_OFF;
			key_nxt = 1'b0;
		end
		next_nxt = next_slot(min_nxt, i_start_min, i_frame_min);
	end

	// Register stage for the whole block.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r <= wbts_pkg::ST_OFF;
			cnt_r <= 32'h0;
			tick_r <= 32'h0;
			idx_r <= 8'h00;
			tone_r <= 2'h0;
			key_r <= 1'b0;
			base_r <= 32'h0;
			freq_r <= '0;
			msg_r <= '0;
			hour_r <= 5'h00;
			min_r <= 6'h00;
			sec_r <= 6'h00;
			next_r <= 6'h00;
			loc_r <= wbts_pkg::LOC_RST;
			pps_d_r <= 1'b0;
			pps_n_r <= 2'h0;
			meas_on_r <= 1'b0;
			meas_r <= 32'h0;
			corr_r <= 32'h0;
			cval_r <= 1'b0;
			gps_done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
			idx_r <= idx_nxt;
			tone_r <= tone_nxt;
			key_r <= key_nxt;
			base_r <= base_nxt;
			freq_r <= freq_nxt;
			msg_r <= msg_nxt;
			hour_r <= hour_nxt;
			min_r <= min_nxt;
			sec_r <= sec_nxt;
			next_r <= next_nxt;
			loc_r <= loc_nxt;
			pps_d_r <= pps_d_nxt;
			pps_n_r <= pps_n_nxt;
			meas_on_r <= meas_on_nxt;
			meas_r <= meas_nxt;
			corr_r <= corr_nxt;
			cval_r <= cval_nxt;
			gps_done_r <= gps_done_nxt;
		end
	end

	// Every output is a register.
	assign o_key = key_r;
	assign o_freq = freq_r;
	assign o_ref_corr = corr_r;
	assign o_corr_valid = cval_r;
	assign o_state = state_r;
	assign o_sym_idx = idx_r;
	assign o_tone = tone_r;
	assign o_hour = hour_r;
	assign o_min = min_r;
	assign o_sec = sec_r;
	assign o_next_min = next_r;
	assign o_locator = loc_r;

	// Checks on keying, symbol stepping and the post-message phase.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	key_whole_a: assert property ((state_r == wbts_pkg::ST_TX) == key_r)
		else $error("key does not match transmit state");
	sym_range_a: assert property (key_r |-> idx_r <= wbts_pkg::SYM_LAST)
		else $error("symbol index out of range");
	freq_map_a: assert property (key_r |-> freq_r == freq_of(base_r, tone_r))
		else $error("frequency does not match tone");
	tone_show_a: assert property (key_r |-> tone_r == msg_r[2*idx_r +: 2])
		else $error("shown tone differs from message");
	sym_hold_a: assert property (key_r && !sym_end && !i_exit |=> $stable(idx_r))
		else $error("symbol advanced early");
	start_even_a: assert property ($rose(key_r) |-> !min_r[0]
		&& sec_r == wbts_pkg::START_SEC)
		else $error("message started off slot");
	last_sym_a: assert property (key_r && sym_end && idx_r == wbts_pkg::SYM_LAST
		&& !i_exit |=> state_r == wbts_pkg::ST_POST && !key_r)
		else $error("no unkey after last symbol");
	exit_now_a: assert property (i_exit |=> state_r == wbts_pkg::ST_OFF && !key_r)
		else $error("exit did not cancel");
	post_len_a: assert property (state_r == wbts_pkg::ST_POST |-> cnt_r < LIMIT_CYC)
		else $error("post-message work too long");
	gps_hold_a: assert property (state_r != wbts_pkg::ST_POST |=> $stable(loc_r))
		else $error("locator changed outside post phase");

	tx_start_c: cover property ($rose(key_r));
	post_end_c: cover property (state_r == wbts_pkg::ST_POST
		##1 state_r == wbts_pkg::ST_WAIT);
	exit_tx_c: cover property (key_r && i_exit);
	corr_c: cover property ($rose(cval_r));

endmodule : wbts_core

// ==== sim/wbts_gps_model.sv ====
// GPS receiver model: free-running pulse per second and decoded fix fields.
`timescale 1ns/10ps
module wbts_gps_model #(
	parameter int PPS_CYC = 38
) (
	// Clock.
	input  wire logic       i_clk,
	// Position chosen by the bench.
	input  wire logic [8:0] i_lon,
	input  wire logic [7:0] i_lat,
	// Receiver outputs.
	output logic            o_pps,
	output logic            o_valid,
	output logic [4:0]      o_hour,
	output logic [5:0]      o_min,
	output logic [5:0]      o_sec,
	output logic [8:0]      o_lon,
	output logic [7:0]      o_lat
);
	int cnt = 0;

	// The pulse runs free and a little fast, so a correction must show up.
	always @(posedge i_clk) begin
		cnt <= (cnt == PPS_CYC - 1) ? 0 : cnt + 1;
	end

	// A real pulse is wide; only its rising edge carries timing.
	assign o_pps = (cnt < 4);
	// The fix is held valid all run, so parsing outside the window shows.
	assign o_valid = 1'b1;
	assign o_hour = 5'h0a;
	assign o_min = 6'h04;
	assign o_sec = 6'h3a;
	assign o_lon = i_lon;
	assign o_lat = i_lat;
endmodule : wbts_gps_model

// ==== sim/tb_top.sv ====
// Self-checking bench for the beacon tone sequencer.
`timescale 1ns/10ps
module tb_top;
	localparam int SYM = 10;
	localparam int SEC = 40;
	localparam int MEAS = 200;
	localparam int PPS = 38;
	logic                        i_clk = 1'b0;
	logic                        i_reset = 1'b1;
	logic                        i_start = 1'b0;
	logic                        i_exit = 1'b0;
	logic [31:0]                 i_base_hz = 32'h0;
	logic [5:0]                  i_frame_min = 6'h04; // Not 2
	logic [5:0]                  i_start_min = 6'h00;
	logic [wbts_pkg::MSG_W-1:0]  i_msg = '0;
	logic [8:0]                  lon = 9'h0, g_lon;
	logic [7:0]                  lat = 8'h0, g_lat;
	logic                        pps, gv, o_key, o_corr_valid;
	logic [4:0]                  g_hour, o_hour;
	logic [5:0]                  g_min, g_sec, o_min, o_sec, o_next_min;
	logic [wbts_pkg::FREQ_W-1:0] o_freq;
	logic [31:0]                 o_ref_corr, o_locator, exp_loc;
	logic [1:0]                  o_state, o_tone;
	logic [7:0]                  o_sym_idx, idx_d;
	logic                        key_d;
	logic [63:0]                 exp_q[$];
	logic [63:0]                 note;
	int                          err_count = 0, samples_checked = 0;
	int                          n, cyc = 0, sym_cnt = 0, seed;

	// Free-running system clock.
	always #2.5 i_clk = ~i_clk;

	wbts_gps_model #(.PPS_CYC(PPS)) gps (.i_clk(i_clk), .i_lon(lon),
		.i_lat(lat), .o_pps(pps), .o_valid(gv), .o_hour(g_hour),
		.o_min(g_min), .o_sec(g_sec), .o_lon(g_lon), .o_lat(g_lat));

	wbts_core #(.SYM_CYC(SYM), .SEC_CYC(SEC), .MEAS_CYC(MEAS),
		.LIMIT_CYC(300)) uut (.i_clk(i_clk), .i_reset(i_reset),
		.i_start(i_start), .i_exit(i_exit), .i_base_hz(i_base_hz),
		.i_frame_min(i_frame_min), .i_start_min(i_start_min),
		.i_msg(i_msg), .i_pps(pps), .i_gps_valid(gv),
		.i_gps_hour(g_hour), .i_gps_min(g_min), .i_gps_sec(g_sec),
		.i_gps_lon(g_lon), .i_gps_lat(g_lat), .o_key(o_key),
		.o_freq(o_freq), .o_ref_corr(o_ref_corr),
		.o_corr_valid(o_corr_valid), .o_state(o_state),
		.o_sym_idx(o_sym_idx), .o_tone(o_tone), .o_hour(o_hour),
		.o_min(o_min), .o_sec(o_sec), .o_next_min(o_next_min),
		.o_locator(o_locator));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("errors=%0d checks=%0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	// Inputs always move one small step after the rising edge.
	task automatic tick(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask : tick

	// Random message and base; every symbol's expected display is queued.
	task automatic load_msg();
		logic [1:0] tn;
		i_base_hz = 32'h00d7_1a68 + $urandom_range(200, 0);
		// Shift in fresh words; the oldest bits fall off the top on purpose.
		for (int i = 0; i < 11; i++)
			i_msg = {i_msg[wbts_pkg::MSG_W-33:0], 32'($urandom)};
		for (int k = 0; k < wbts_pkg::NSYM; k++) begin
			tn = i_msg[2*k +: 2];
			exp_q.push_back(64'({8'(k), tn,
				45'(i_base_hz) * 45'(wbts_pkg::TONE_DEN) +
				45'(tn) * 45'(wbts_pkg::TONE_NUM)}));
		end
	endtask : load_msg

	// Bounded wait for keying; a slot is at most a few minutes away.
	task automatic wait_key();
		for (n = 0; n < 12000 && o_key !== 1'b1; n++)
			tick(1);
	endtask : wait_key

	// Each new symbol on air retires the oldest note; all but a message's first are timed.
	// Outputs are read on the falling edge, where they have settled.
	always @(negedge i_clk) begin
		if (!i_reset && o_key === 1'b1 &&
			(key_d !== 1'b1 || o_sym_idx !== idx_d)) begin
			if (key_d === 1'b1)
				chk(64'(sym_cnt), 64'(SYM));
			sym_cnt <= 1;
			if (exp_q.size() == 0) begin
				chk(64'h1, 64'h0);
			end else begin
				note = exp_q.pop_front();
				chk(64'({o_sym_idx, o_tone, o_freq}), note);
			end
		end else begin
			sym_cnt <= sym_cnt + 1;
		end
		key_d <= o_key;
		idx_d <= o_sym_idx;
	end

	// A hang is cut short well past the expected run length.
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 15000) begin
			err_count++;
			end_sim();
		end
	end

	initial begin
		seed = $urandom(52);
		lon = 9'($urandom_range(359, 0));
		lat = 8'($urandom_range(179, 0));
		exp_loc = {8'(wbts_pkg::ASCII_A + lon / wbts_pkg::LON_FIELD),
			8'(wbts_pkg::ASCII_A + lat / wbts_pkg::LAT_FIELD),
			8'(wbts_pkg::ASCII_0 + (lon % wbts_pkg::LON_FIELD) / wbts_pkg::LON_SQ),
			8'(wbts_pkg::ASCII_0 + lat % wbts_pkg::LAT_FIELD)};
		tick(3);
		i_reset = 1'b0;
		chk(64'({o_key, o_state, o_corr_valid}), 64'h0);
		chk(64'(o_locator), 64'(wbts_pkg::LOC_RST));
		load_msg();
		i_start = 1'b1;
		tick(1);
		i_start = 1'b0;
		chk(64'(o_state), 64'h1);
		// The fix is valid now, yet the clock must keep counting from zero.
		wait_key();
		chk(64'({o_hour, o_min, o_sec}), 64'h1);
		for (n = 0; n < 2000 && o_key === 1'b1; n++)
			tick(1);
		chk(64'(n), 64'(wbts_pkg::NSYM * SYM));
		chk(64'(o_state), 64'h3);
		chk(64'(exp_q.size()), 64'h0);
		tick(2);
		chk(64'({o_hour, o_min, o_sec}), 64'({5'h0a, 6'h04, 6'h3a}));
		chk(64'(o_locator), 64'(exp_loc));
		for (n = 2; n < 400 && o_state === 2'b11; n++)
			tick(1);
		chk(64'(n), 64'(MEAS));
		chk(64'(o_state), 64'h1);
		chk(64'({o_corr_valid, o_ref_corr}),
			64'({1'b1, 32'(3 * SEC - 3 * PPS)}));
		i_start_min = 6'h02;
		tick(2);
		chk(64'(o_next_min), 64'h6);
		load_msg();
		wait_key();
		chk(64'({o_hour, o_min, o_sec}), 64'({5'h0a, 6'h06, 6'h01}));
		tick(5 * SYM);
		i_exit = 1'b1;
		tick(1);
		i_exit = 1'b0;
		chk(64'({o_key, o_state}), 64'h0);
		exp_q.delete();
		tick(3 * SYM);
		chk(64'({o_key, o_state}), 64'h0);
		end_sim();
	end
endmodule : tb_top
